// File: fdma_params.svh
`ifndef FDMA_PARAMS_SVH
`define FDMA_PARAMS_SVH

// Port addresses on the host I/O space.
`define FDMA_A_C1_CNT 16'h0003
`define FDMA_A_C2_ADDR 16'h0004
`define FDMA_A_C2_CNT 16'h0005
`define FDMA_A_C3_ADDR 16'h0006
`define FDMA_A_C3_CNT 16'h0007
`define FDMA_A_CMD 16'h0008
`define FDMA_A_REQ 16'h0009
`define FDMA_A_MASK 16'h000A
`define FDMA_A_MODE 16'h000B
`define FDMA_A_PTR_CLR 16'h000C
`define FDMA_A_PAGE2 16'h0081
`define FDMA_A_PAGE3 16'h0082
`define FDMA_A_PAGE01 16'h0083

// Command register bit positions.
`define FDMA_CMD_M2M 0
`define FDMA_CMD_HOLD0 1
`define FDMA_CMD_DIS 2
`define FDMA_CMD_COMP 3
`define FDMA_CMD_ROT 4
`define FDMA_CMD_EXTW 5
`define FDMA_CMD_REQLO 6
`define FDMA_CMD_ACKHI 7

// Stored mode field (write data bits 7:2 kept as bits 5:0).
`define FDMA_MODE_AUTO 2
`define FDMA_MODE_DEC 3

// Reset values, and the byte returned by reads of write-only or unmapped ports.
`define FDMA_CMD_RST 8'h00
`define FDMA_MASK_RST 4'hF
`define FDMA_ILLEGAL_RD 8'h00

// Memory request kinds carried in the FIFO word.
`define FDMA_KIND_WRITE 2'h0
`define FDMA_KIND_READ 2'h1
`define FDMA_KIND_SRC 2'h2
`define FDMA_KIND_DST 2'h3

// FIFO shape: kind, 20-bit address, data byte.
`define FDMA_FIFO_W 30
`define FDMA_FIFO_D 16

`endif

// File: fdma_pkg.sv
package fdma_pkg;

  // Engine states.
  typedef enum logic {
    FDMA_IDLE,
    FDMA_XFER
  } fdma_state_e;

  // Service mode, in the order of mode bits 7:6.
  typedef enum logic [1:0] {
    FDMA_SVC_DEMAND,
    FDMA_SVC_SINGLE,
    FDMA_SVC_BLOCK,
    FDMA_SVC_CASCADE
  } fdma_svc_e;

  // Transfer type, in the order of mode bits 3:2.
  typedef enum logic [1:0] {
    FDMA_TYPE_VERIFY,
    FDMA_TYPE_WRITE,
    FDMA_TYPE_READ,
    FDMA_TYPE_ILLEGAL
  } fdma_type_e;

  // One memory request word.
  typedef logic [29:0] fdma_word_t;

endpackage

// File: fdma_top.sv
`timescale 1ns/100ps
`include "fdma_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Parameterised FIFO between the transfer engine and the memory side.
module fdma_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Filling side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Draining side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // Storage array.
  logic [AW-1:0] wr_ptr, next_wr_ptr; // Next slot to fill.
  logic [AW-1:0] rd_ptr, next_rd_ptr; // Oldest slot.
  logic [AW:0] count, next_count; // Words held.
  logic push; // A word enters this cycle.
  logic pop; // A word leaves this cycle.

  // Full and empty come from the count, so they never lie.
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Pointer and count update.
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // Registers; the array needs no reset since count guards it.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Four-channel transfer controller with its I/O-mapped programming ports.
module fdma_top (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Host I/O port; data is a two-way pin split in three.
  input wire logic [15:0] io_addr_i,
  input wire logic io_write_strobe_n_i,
  input wire logic io_read_strobe_n_i,
  input wire logic [7:0] io_data_i,
  output logic [7:0] io_data_o,
  output logic io_data_oe_o,
  // Peripheral handshake.
  input wire logic [3:0] transfer_request_input_i,
  output logic [3:0] transfer_acknowledge_output_o,
  output logic terminal_count_o,
  input wire logic [7:0] periph_data_i,
  // Memory request stream.
  output logic mem_valid_o,
  input wire logic mem_ready_i,
  output logic [1:0] mem_kind_o,
  output logic [19:0] mem_addr_o,
  output logic [7:0] mem_data_o,
  // Cycle timing selection for the memory side.
  output logic compressed_timing_o,
  output logic extended_write_o
);
  import fdma_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State.
  logic [15:0] base_addr [4], next_base_addr [4]; // Reload address.
  logic [15:0] cur_addr [4], next_cur_addr [4]; // Working address.
  logic [15:0] base_cnt [4], next_base_cnt [4]; // Reload count.
  logic [15:0] cur_cnt [4], next_cur_cnt [4]; // Working count.
  logic [5:0] mode [4], next_mode [4]; // Mode bits 7:2 per channel.
  logic [3:0] page01, next_page01; // Shared page of channels 0 and 1.
  logic [3:0] page2, next_page2; // Channel 2 page.
  logic [3:0] page3, next_page3; // Channel 3 page.
  logic [7:0] cmd, next_cmd; // Command register.
  logic [3:0] mask, next_mask; // Channel masks.
  logic [3:0] sw_req, next_sw_req; // Software requests.
  logic [3:0] tc_flag, next_tc_flag; // Sticky terminal count flags.
  logic byte_ptr, next_byte_ptr; // High byte when set.
  logic iow_prev, next_iow_prev; // Write strobe one cycle back.
  logic ior_prev, next_ior_prev; // Read strobe one cycle back.
  fdma_state_e state, next_state; // Engine state.
  logic [1:0] chan, next_chan; // Channel in service.
  logic [1:0] last, next_last; // Last served, lowest when rotating.
  logic gap, next_gap; // Idle cycle of normal timing.
  logic phase, next_phase; // Copy mode: destination half.
  // Registered outputs.
  logic [7:0] next_io_data;
  logic next_io_data_oe;
  logic [3:0] next_ack;
  logic next_tc_out;
  logic next_mem_valid;
  fdma_word_t next_mem_word;
  logic next_comp;
  logic next_extw;

  // FIFO hookup.
  logic push_valid; // Engine offers a word.
  fdma_word_t push_word; // Word offered.
  logic fifo_in_ready; // FIFO has room.
  logic fifo_out_valid; // FIFO holds a word.
  logic fifo_out_ready; // Output stage takes a word.
  fdma_word_t fifo_out_word; // Oldest FIFO word.

  logic [3:0] req_on; // Request inputs after polarity.
  logic [3:0] elig; // Channels asking for service.

  //////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Picks the next channel; fixed order starts at 0, rotating after last.
  function automatic logic [2:0] pick(input logic [3:0] want, input logic rot,
                                      input logic [1:0] lo);
    logic [2:0] res;
    logic [1:0] idx;
    res = 3'h0;
    for (int k = 3; k >= 0; k--) begin
      idx = rot ? lo + 2'(k + 1) : 2'(k);
      if (want[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction

  // Page bits for a channel; never touched by the 16-bit counter.
  function automatic logic [3:0] page_of(input logic [1:0] c, input logic [3:0] p01,
                                         input logic [3:0] p2, input logic [3:0] p3);
    return (c == 2'h2) ? p2 : (c == 2'h3) ? p3 : p01;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Request sense, one slice per channel.
  for (genvar g = 0; g < 4; g++) begin : g_req
    assign req_on[g] = transfer_request_input_i[g] ^ cmd[`FDMA_CMD_REQLO];
    // Masks block the pin only; a software request always counts.
    assign elig[g] = (req_on[g] & ~mask[g]) | sw_req[g];
  end

  //////////////////////////////////////////////////////////////////////////////
  // FIFO in the memory request path; a full FIFO stalls the engine.
  fdma_fifo #(
    .WIDTH(`FDMA_FIFO_W),
    .DEPTH(`FDMA_FIFO_D)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .in_valid_i(push_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_word)
  );

  assign fifo_out_ready = ~mem_valid_o | mem_ready_i;

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic for host ports, engine and outputs.
  always_comb begin
    logic wr;
    logic rd;
    logic [7:0] d;
    logic [2:0] sel;
    logic m2m;
    logic comp;
    logic [1:0] x;
    logic [1:0] ty;
    logic [1:0] svc;
    logic tc;
    wr = 1'b0;
    rd = 1'b0;
    d = io_data_i;
    sel = 3'h0;
    m2m = 1'b0;
    comp = 1'b0;
    x = 2'h0;
    ty = 2'h0;
    svc = 2'h0;
    tc = 1'b0;
    next_base_addr = base_addr;
    next_cur_addr = cur_addr;
    next_base_cnt = base_cnt;
    next_cur_cnt = cur_cnt;
    next_mode = mode;
    next_page01 = page01;
    next_page2 = page2;
    next_page3 = page3;
    next_cmd = cmd;
    next_mask = mask;
    next_sw_req = sw_req;
    next_tc_flag = tc_flag;
    next_byte_ptr = byte_ptr;
    next_iow_prev = io_write_strobe_n_i;
    next_ior_prev = io_read_strobe_n_i;
    next_state = state;
    next_chan = chan;
    next_last = last;
    next_gap = gap;
    next_phase = phase;
    next_io_data = io_data_o;
    next_tc_out = 1'b0;
    push_valid = 1'b0;
    push_word = '0;

    // An access is taken on the first cycle its strobe is seen low.
    wr = iow_prev & ~io_write_strobe_n_i;
    rd = ior_prev & ~io_read_strobe_n_i;

    // Host writes.
    if (wr) begin
      unique case (io_addr_i)
        `FDMA_A_C1_CNT, `FDMA_A_C2_CNT, `FDMA_A_C3_CNT: begin
          x = io_addr_i[2:1];
          // Both base and current take the byte the pointer names.
          if (byte_ptr) begin
            next_base_cnt[x][15:8] = d;
            next_cur_cnt[x][15:8] = d;
          end else begin
            next_base_cnt[x][7:0] = d;
            next_cur_cnt[x][7:0] = d;
          end
          next_byte_ptr = ~byte_ptr;
        end
        `FDMA_A_C2_ADDR, `FDMA_A_C3_ADDR: begin
          x = io_addr_i[2:1];
          if (byte_ptr) begin
            next_base_addr[x][15:8] = d;
            next_cur_addr[x][15:8] = d;
          end else begin
            next_base_addr[x][7:0] = d;
            next_cur_addr[x][7:0] = d;
          end
          next_byte_ptr = ~byte_ptr;
        end
        `FDMA_A_CMD: next_cmd = d;
        `FDMA_A_REQ: next_sw_req[d[1:0]] = d[2];
        `FDMA_A_MASK: next_mask[d[1:0]] = d[2];
        `FDMA_A_MODE: next_mode[d[1:0]] = d[7:2];
        `FDMA_A_PTR_CLR: next_byte_ptr = 1'b0;
        `FDMA_A_PAGE2: next_page2 = d[3:0];
        `FDMA_A_PAGE3: next_page3 = d[3:0];
        `FDMA_A_PAGE01: next_page01 = d[3:0];
        default: begin
        end
      endcase
    end

    // Host reads; data is caught on the strobe's first low cycle.
    if (rd) begin
      next_io_data = `FDMA_ILLEGAL_RD;
      unique case (io_addr_i)
        `FDMA_A_C1_CNT, `FDMA_A_C2_CNT, `FDMA_A_C3_CNT: begin
          x = io_addr_i[2:1];
          next_io_data = byte_ptr ? cur_cnt[x][15:8] : cur_cnt[x][7:0];
          next_byte_ptr = ~byte_ptr;
        end
        `FDMA_A_C2_ADDR, `FDMA_A_C3_ADDR: begin
          x = io_addr_i[2:1];
          next_io_data = byte_ptr ? cur_addr[x][15:8] : cur_addr[x][7:0];
          next_byte_ptr = ~byte_ptr;
        end
        `FDMA_A_CMD: begin
          next_io_data = {elig, tc_flag};
          next_tc_flag = 4'h0; // Flags clear on read; a new one set below wins.
        end
        default: begin
        end
      endcase
    end

    // Timing selections; compressed is void in copy mode.
    comp = cmd[`FDMA_CMD_COMP] & ~cmd[`FDMA_CMD_M2M];
    next_comp = comp;
    next_extw = cmd[`FDMA_CMD_EXTW] & ~comp;

    // Transfer engine.
    unique case (state)
      FDMA_IDLE: begin
        sel = pick(elig, cmd[`FDMA_CMD_ROT], last);
        if (!cmd[`FDMA_CMD_DIS] && sel[2]) begin
          next_state = FDMA_XFER;
          next_chan = sel[1:0];
          next_last = sel[1:0];
          next_gap = 1'b0;
          next_phase = 1'b0;
        end
      end
      FDMA_XFER: begin
        m2m = cmd[`FDMA_CMD_M2M] && (chan == 2'h0);
        svc = mode[chan][5:4];
        ty = mode[chan][1:0];
        // Copy mode counts on channel 1; otherwise on the served channel.
        x = m2m ? 2'h1 : chan;
        if (cmd[`FDMA_CMD_DIS]) begin
          next_state = FDMA_IDLE;
        end else if (!m2m && svc == FDMA_SVC_CASCADE) begin
          // Cascade only passes the acknowledge; type is void here.
          if (!elig[chan]) begin
            next_state = FDMA_IDLE;
          end
        end else if (gap) begin
          next_gap = 1'b0;
        end else if (!m2m && svc == FDMA_SVC_DEMAND && !elig[chan]) begin
          next_state = FDMA_IDLE;
        end else if ((m2m || ty == FDMA_TYPE_WRITE || ty == FDMA_TYPE_READ) &&
                     !fifo_in_ready) begin
          // Stall with acknowledge held until the FIFO has room.
        end else if (m2m && !phase) begin
          // Source half of a copy: read at channel 0.
          push_valid = 1'b1;
          push_word = {`FDMA_KIND_SRC, page01, cur_addr[0], 8'h00};
          if (!cmd[`FDMA_CMD_HOLD0]) begin
            next_cur_addr[0] = mode[0][`FDMA_MODE_DEC] ? cur_addr[0] - 16'h0001
                                                        : cur_addr[0] + 16'h0001;
          end
          next_phase = 1'b1;
          next_gap = ~comp;
        end else begin
          if (m2m) begin
            push_valid = 1'b1;
            push_word = {`FDMA_KIND_DST, page01, cur_addr[1], 8'h00};
          end else if (ty == FDMA_TYPE_WRITE) begin
            push_valid = 1'b1;
            push_word = {`FDMA_KIND_WRITE, page_of(chan, page01, page2, page3),
                         cur_addr[chan], periph_data_i};
          end else if (ty == FDMA_TYPE_READ) begin
            push_valid = 1'b1;
            push_word = {`FDMA_KIND_READ, page_of(chan, page01, page2, page3),
                         cur_addr[chan], 8'h00};
          end
          // Verify and the illegal type step counters with no memory cycle.
          tc = (cur_cnt[x] == 16'h0000);
          next_cur_addr[x] = mode[x][`FDMA_MODE_DEC] ? cur_addr[x] - 16'h0001
                                                      : cur_addr[x] + 16'h0001;
          next_cur_cnt[x] = cur_cnt[x] - 16'h0001;
          next_phase = 1'b0;
          next_gap = ~comp;
          if (tc) begin
            next_tc_flag[x] = 1'b1;
            next_tc_out = 1'b1;
            next_sw_req[chan] = 1'b0;
            if (mode[x][`FDMA_MODE_AUTO]) begin
              next_cur_addr[x] = base_addr[x];
              next_cur_cnt[x] = base_cnt[x];
            end
          end
          if (tc || (!m2m && svc == FDMA_SVC_SINGLE)) begin
            next_state = FDMA_IDLE;
          end
        end
      end
    endcase

    // Acknowledge for the channel in service, at the chosen polarity.
    for (int i = 0; i < 4; i++) begin
      next_ack[i] = ((next_state == FDMA_XFER) && (next_chan == 2'(i)) &&
                     !(cmd[`FDMA_CMD_M2M] && next_chan == 2'h0)) ~^
                    cmd[`FDMA_CMD_ACKHI];
    end

    // Data pin is driven while a read of a readable port is under way.
    next_io_data_oe = ~io_read_strobe_n_i &&
                      (io_addr_i >= `FDMA_A_C1_CNT) && (io_addr_i <= `FDMA_A_CMD);

    // Output stage of the memory stream.
    next_mem_valid = mem_valid_o;
    next_mem_word = {mem_kind_o, mem_addr_o, mem_data_o};
    if (fifo_out_ready) begin
      next_mem_valid = fifo_out_valid;
      next_mem_word = fifo_out_word;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers only.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < 4; i++) begin
        base_addr[i] <= 16'h0000;
        cur_addr[i] <= 16'h0000;
        base_cnt[i] <= 16'h0000;
        cur_cnt[i] <= 16'h0000;
        mode[i] <= 6'h00;
      end
      page01 <= 4'h0;
      page2 <= 4'h0;
      page3 <= 4'h0;
      cmd <= `FDMA_CMD_RST;
      mask <= `FDMA_MASK_RST;
      sw_req <= 4'h0;
      tc_flag <= 4'h0;
      byte_ptr <= 1'b0;
      iow_prev <= 1'b1;
      ior_prev <= 1'b1;
      state <= FDMA_IDLE;
      chan <= 2'h0;
      last <= 2'h3;
      gap <= 1'b0;
      phase <= 1'b0;
      io_data_o <= 8'h00;
      io_data_oe_o <= 1'b0;
      transfer_acknowledge_output_o <= 4'hF;
      terminal_count_o <= 1'b0;
      mem_valid_o <= 1'b0;
      {mem_kind_o, mem_addr_o, mem_data_o} <= '0;
      compressed_timing_o <= 1'b0;
      extended_write_o <= 1'b0;
    end else begin
      base_addr <= next_base_addr;
      cur_addr <= next_cur_addr;
      base_cnt <= next_base_cnt;
      cur_cnt <= next_cur_cnt;
      mode <= next_mode;
      page01 <= next_page01;
      page2 <= next_page2;
      page3 <= next_page3;
      cmd <= next_cmd;
      mask <= next_mask;
      sw_req <= next_sw_req;
      tc_flag <= next_tc_flag;
      byte_ptr <= next_byte_ptr;
      iow_prev <= next_iow_prev;
      ior_prev <= next_ior_prev;
      state <= next_state;
      chan <= next_chan;
      last <= next_last;
      gap <= next_gap;
      phase <= next_phase;
      io_data_o <= next_io_data;
      io_data_oe_o <= next_io_data_oe;
      transfer_acknowledge_output_o <= next_ack;
      terminal_count_o <= next_tc_out;
      mem_valid_o <= next_mem_valid;
      {mem_kind_o, mem_addr_o, mem_data_o} <= next_mem_word;
      compressed_timing_o <= next_comp;
      extended_write_o <= next_extw;
    end
  end
endmodule

// File: fdma_top_sva.sv
`timescale 1ns/100ps
`include "fdma_params.svh"
// Port-level checks of the transfer controller.
module fdma_top_chk (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Host port.
  input wire logic [15:0] io_addr_i,
  input wire logic io_read_strobe_n_i,
  input wire logic [7:0] io_data_o,
  input wire logic io_data_oe_o,
  // Transfer side.
  input wire logic [3:0] transfer_acknowledge_output_o,
  input wire logic terminal_count_o,
  input wire logic mem_valid_o,
  input wire logic mem_ready_i,
  input wire logic [19:0] mem_addr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  logic rd_ok, rd_wo; // Reads of readable and of write-only ports.
  assign rd_ok = !io_read_strobe_n_i && io_addr_i inside {[16'h0003:16'h0008]};
  assign rd_wo = !io_read_strobe_n_i &&
    io_addr_i inside {[16'h0009:16'h000C], [16'h0081:16'h0083]};
  a_oe_on_read: assert property (
    rd_ok |=> io_data_oe_o) else $error("read port not driven");
  a_wo_no_drive: assert property (
    rd_wo |=> !io_data_oe_o) else $error("write-only port driven");
  a_wo_read_zero: assert property (
    $fell(io_read_strobe_n_i) && rd_wo |-> ##2 io_data_o == `FDMA_ILLEGAL_RD)
    else $error("write-only port read nonzero");
  a_oe_release: assert property (
    $rose(io_read_strobe_n_i) |-> ##2 !io_data_oe_o) else $error("bus held after read");
  a_tc_one_cycle: assert property (
    terminal_count_o |=> !terminal_count_o) else $error("terminal count too long");
  a_tc_after_xfer: assert property (
    terminal_count_o |-> !($past(transfer_acknowledge_output_o) inside {4'h0, 4'hF}))
    else $error("terminal count without transfer");
  a_mem_word_hold: assert property (
    mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_addr_o))
    else $error("memory word dropped");
  a_ack_one_chan: assert property (
    $onehot0(transfer_acknowledge_output_o) || $onehot0(~transfer_acknowledge_output_o))
    else $error("several acknowledges");
  c_tc: cover property (terminal_count_o);
  c_stall: cover property (mem_valid_o && !mem_ready_i);
  c_read: cover property (rd_ok ##1 io_data_oe_o);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind fdma_top fdma_top_chk i_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
  .io_addr_i(io_addr_i), .io_read_strobe_n_i(io_read_strobe_n_i), .io_data_o(io_data_o),
  .io_data_oe_o(io_data_oe_o), .transfer_acknowledge_output_o(transfer_acknowledge_output_o),
  .terminal_count_o(terminal_count_o), .mem_valid_o(mem_valid_o),
  .mem_ready_i(mem_ready_i), .mem_addr_o(mem_addr_o));

// File: fdma_periph_model.sv
`timescale 1ns/100ps
// Peripherals and memory on the far side of the controller.
module fdma_periph_model (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Bench controls and controller outputs.
  input wire logic [3:0] want_i,
  input wire logic stall_i,
  input wire logic tc_i,
  input wire logic mem_valid_i,
  input wire logic [1:0] mem_kind_i,
  input wire logic [19:0] mem_addr_i,
  input wire logic [7:0] mem_data_i,
  // Drives back into the controller.
  output logic [3:0] req_o,
  output logic [7:0] pdata_o,
  output logic mem_ready_o
);
  logic [3:0] stop = 4'h0; // Requests already ended by terminal count.
  logic [7:0] cnt = 8'h00; // Peripheral byte source.
  logic [21:0] got[$]; // Accepted words, kind above address.
  logic [7:0] dat[$]; // Data bytes of the accepted words, in the same order.
  // A peripheral drops its request at once when terminal count is signalled.
  assign req_o = want_i & ~stop & ~{4{tc_i}};
  assign mem_ready_o = !stall_i;
  assign pdata_o = cnt;
  // The byte changes every cycle, so a stale sample cannot match by luck.
  always @(posedge ref_clk_i) begin
    cnt <= srst_i ? 8'h00 : cnt + 8'h01;
    stop <= (srst_i || want_i == 4'h0) ? 4'h0 : stop | (want_i & {4{tc_i}});
    if (!srst_i && mem_valid_i && mem_ready_o) begin
      got.push_back({mem_kind_i, mem_addr_i});
      dat.push_back(mem_data_i);
    end
  end
endmodule

// File: fdma_top_test.sv
`timescale 1ns/100ps
// Bench for the transfer controller; every scenario judges its own results.
module fdma_top_test;
  logic clk = 1'b0, srst = 1'b1, wr_n = 1'b1, rd_n = 1'b1, stall = 1'b0;
  logic oe, tc, mv, mr, comp, extw;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdat = 8'h00, rdat, pdat, mdat;
  logic [3:0] req, ack, want = 4'h0;
  logic [1:0] kind;
  logic [19:0] maddr;
  int n_errors = 0;
  int compares = 0;
  always #12.5 clk = ~clk;
  fdma_top i_dut (.ref_clk_i(clk), .srst_i(srst), .io_addr_i(addr), .io_write_strobe_n_i(wr_n),
    .io_read_strobe_n_i(rd_n), .io_data_i(wdat), .io_data_o(rdat), .io_data_oe_o(oe),
    .transfer_request_input_i(req), .transfer_acknowledge_output_o(ack),
    .terminal_count_o(tc), .periph_data_i(pdat), .mem_valid_o(mv), .mem_ready_i(mr),
    .mem_kind_o(kind), .mem_addr_o(maddr), .mem_data_o(mdat), .compressed_timing_o(comp),
    .extended_write_o(extw));
  fdma_periph_model i_mdl (.ref_clk_i(clk), .srst_i(srst), .want_i(want), .stall_i(stall),
    .tc_i(tc), .mem_valid_i(mv), .mem_kind_i(kind), .mem_addr_i(maddr), .mem_data_i(mdat),
    .req_o(req), .pdata_o(pdat), .mem_ready_o(mr));
  //////////////////////////////////////////////////////////////////////////////
  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t ns: %s", $time, msg);
    end
  endtask
  // Host write; the strobe stays low two edges but only the first is taken.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr_n <= 1'b0;
    repeat (2) @(posedge clk);
    wr_n <= 1'b1;
    @(posedge clk);
  endtask
  // Host read, judged after the answer has settled.
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic eoe);
    @(posedge clk);
    addr <= a;
    rd_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(rdat === e && oe === eoe, "read data or drive");
    @(posedge clk);
    rd_n <= 1'b1;
    @(posedge clk);
  endtask
  // Bounded wait for n words at the memory side; a hang ends the run.
  task automatic wait_words(input int n);
    int i;
    for (i = 0; i < 3000 && i_mdl.got.size() < n; i++) @(posedge clk);
    chk(i_mdl.got.size() == n, "memory word count");
    if (i_mdl.got.size() < n) summarize();
  endtask
  // Every 16-bit register byte by byte, then a pointer clear between bytes.
  task automatic t_regs();
    for (logic [7:0] p = 8'h03; p < 8'h08; p++) begin
      wr(16'(p), 8'hA0 + p);
      wr(16'(p), 8'h50 + p);
      rd(16'(p), 8'hA0 + p, 1'b1);
      rd(16'(p), 8'h50 + p, 1'b1);
    end
    rd(16'h0004, 8'hA4, 1'b1);
    wr(16'h000C, 8'hFF);
    rd(16'h0004, 8'hA4, 1'b1);
  endtask
  // Write-only and unmapped ports read as zero and leave the bus undriven.
  task automatic t_illegal();
    logic [15:0] wo[8] = '{16'h0009, 16'h000A, 16'h000B, 16'h000C, 16'h0081, 16'h0082,
      16'h0083, 16'h0010};
    for (int i = 0; i < 8; i++) rd(wo[i], 8'h00, 1'b0);
  endtask
  // Timing and polarity selections, the ignored combinations among them.
  task automatic t_cmd();
    logic [10:0] t[7] = '{11'h045, 11'h049, 11'h103, 11'h145, 11'h14B, 11'h400, 11'h001};
    for (int i = 0; i < 7; i++) begin
      wr(16'h0008, t[i][10:3]);
      repeat (2) @(posedge clk);
      #1;
      chk({comp, extw, ack} === {t[i][2:1], {4{t[i][0]}}}, "timing or polarity");
    end
  endtask
  // Single-mode channel 2 fills the buffer while memory stalls, then drains.
  task automatic t_fifo();
    wr(16'h0081, 8'hF5);
    wr(16'h000C, 8'h00);
    wr(16'h0004, 8'h00);
    wr(16'h0004, 8'h10);
    wr(16'h0005, 8'd19);
    wr(16'h0005, 8'h00);
    wr(16'h000B, 8'h46);
    wr(16'h000A, 8'h02);
    stall <= 1'b1;
    want <= 4'h4;
    repeat (150) @(posedge clk);
    chk(ack === 4'hB && mv === 1'b1 && i_mdl.got.size() == 0, "stalled service");
    stall <= 1'b0;
    wait_words(20);
    for (int k = 0; k < 20; k++) chk(i_mdl.got[k] === {2'h0, 20'h51000 + 20'(k)}, "word");
    want <= 4'h0;
    rd(16'h0008, 8'h04, 1'b1);
    rd(16'h0008, 8'h00, 1'b1);
  endtask
  // Software-started block on channel 3 held off, then counting down past zero.
  task automatic t_auto();
    i_mdl.got.delete();
    i_mdl.dat.delete();
    wr(16'h0082, 8'h0A);
    wr(16'h0006, 8'h00);
    wr(16'h0006, 8'h00);
    wr(16'h0007, 8'h01);
    wr(16'h0007, 8'h00);
    wr(16'h000B, 8'hB7);
    wr(16'h0008, 8'h04);
    wr(16'h0009, 8'h07);
    rd(16'h0008, 8'h80, 1'b1);
    chk(i_mdl.got.size() == 0, "disabled controller served");
    wr(16'h0008, 8'h00);
    wait_words(2);
    chk(i_mdl.got[0] === 22'h0A0000 && i_mdl.got[1] === 22'h0AFFFF, "down words");
    // Normal timing serves a block every second cycle, so the sampled bytes differ by two.
    chk(i_mdl.dat[1] - i_mdl.dat[0] === 8'h02, "normal timing spacing");
    rd(16'h0008, 8'h08, 1'b1);
    rd(16'h0006, 8'h00, 1'b1);
    rd(16'h0006, 8'h00, 1'b1);
    rd(16'h0007, 8'h01, 1'b1);
    // Low-active sense with idle pins makes unmasked channel 2 pending; disabled, none served.
    wr(16'h0008, 8'h44);
    rd(16'h0008, 8'h40, 1'b1);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk(ack === 4'hF && mv === 1'b0 && oe === 1'b0 && tc === 1'b0, "reset state");
    t_regs();
    t_illegal();
    t_cmd();
    t_fifo();
    t_auto();
    summarize();
  end
endmodule
